// [rtl/robu_defs.svh]
`ifndef ROBU_DEFS_SVH
`define ROBU_DEFS_SVH

// Register byte addresses
`define ROBU_ADDR_SHIFT 32'h0fffe000
`define ROBU_ADDR_RMASK 32'h0fffe004
`define ROBU_ADDR_LMASK 32'h0fffe008
`define ROBU_ADDR_FUNC 32'hffffe00c
`define ROBU_ADDR_CTRL 32'hffffe010
`define ROBU_ADDR_COUNT 32'hffffe014

// Register indices into the configuration array
`define ROBU_IDX_SHIFT 3'h0
`define ROBU_IDX_RMASK 3'h1
`define ROBU_IDX_LMASK 3'h2
`define ROBU_IDX_FUNC 3'h3
`define ROBU_IDX_CTRL 3'h4
`define ROBU_IDX_COUNT 3'h5
`define ROBU_IDX_NONE 3'h7
`define ROBU_NUM_REGS 6

// Implemented bits of each register
`define ROBU_IMPL_SHIFT 8'h1f
`define ROBU_IMPL_RMASK 8'h0f
`define ROBU_IMPL_LMASK 8'h0f
`define ROBU_IMPL_FUNC 8'h0f
`define ROBU_IMPL_CTRL 8'hf6
`define ROBU_IMPL_COUNT 8'hff

// Reset values
`define ROBU_RST_REG 8'h00
`define ROBU_RST_UNMAPPED 8'h00

// Field positions
`define ROBU_SHIFT_MSB 3
`define ROBU_SHIFT_LSB 0
`define ROBU_SWAP_BIT 4
`define ROBU_IDX_MSB 3
`define ROBU_IDX_LSB 0
`define ROBU_CTL_BEGIN_RIGHT_MASK_EN 7
`define ROBU_CTL_BEGIN_LEFT_MASK_EN 6
`define ROBU_CTL_END_RIGHT_MASK_EN 5
`define ROBU_CTL_END_LEFT_MASK_EN 4
`define ROBU_CTL_EN 2
`define ROBU_CTL_PRERD 1

// Word counter value on the last word of a scan line
`define ROBU_LAST_COUNT 8'hff

`endif

// [rtl/robu_pkg.sv]
package robu_pkg;

  typedef enum logic [1:0] {
    ROBU_IDLE = 2'b00,
    ROBU_PREREAD = 2'b01,
    ROBU_RUN = 2'b10
  } robu_state_type;

  typedef enum logic [3:0] {
    ROBU_FN_ZERO = 4'h0,
    ROBU_FN_S_AND_D = 4'h1,
    ROBU_FN_S_AND_ND = 4'h2,
    ROBU_FN_S = 4'h3,
    ROBU_FN_NS_AND_D = 4'h4,
    ROBU_FN_D = 4'h5,
    ROBU_FN_S_XOR_D = 4'h6,
    ROBU_FN_S_OR_D = 4'h7,
    ROBU_FN_NS_AND_ND = 4'h8,
    ROBU_FN_S_XNOR_D = 4'h9,
    ROBU_FN_ND = 4'ha,
    ROBU_FN_S_OR_ND = 4'hb,
    ROBU_FN_NS = 4'hc,
    ROBU_FN_NS_OR_D = 4'hd,
    ROBU_FN_NS_OR_ND = 4'he,
    ROBU_FN_ONES = 4'hf
  } robu_fn_type;

  typedef logic [15:0] robu_word_type;

endpackage : robu_pkg

// [rtl/robu_mask_gen.sv]
`timescale 1ns/1ps
`default_nettype none

module robu_mask_gen
  import robu_pkg::*;
(
  input wire logic [3:0] rightIdx,
  input wire logic [3:0] leftIdx,
  output robu_word_type rightMask,
  output robu_word_type leftMask
);

  // Bit 0 is the leftmost pixel of the word
  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1)
    begin : gen_bit
      assign rightMask[i] = (4'(i) <= rightIdx); // [RL6] [RL8]
      assign leftMask[i] = (4'(i) >= leftIdx); // [RL7] [RL8]
    end
  endgenerate

endmodule : robu_mask_gen

`default_nettype wire

// [rtl/robu_logic_fn.sv]
`timescale 1ns/1ps
`default_nettype none

module robu_logic_fn
  import robu_pkg::*;
(
  input wire logic [3:0] fnCode,
  input wire robu_word_type srcWord,
  input wire robu_word_type dstWord,
  input wire robu_word_type maskWord,
  output robu_word_type resWord
);

  robu_word_type fnOut;

  always_comb
  begin
    case (robu_fn_type'(fnCode)) // [RL10]
      ROBU_FN_ZERO: fnOut = 16'h0000;
      ROBU_FN_S_AND_D: fnOut = srcWord & dstWord;
      ROBU_FN_S_AND_ND: fnOut = srcWord & ~dstWord;
      ROBU_FN_S: fnOut = srcWord;
      ROBU_FN_NS_AND_D: fnOut = ~srcWord & dstWord;
      ROBU_FN_D: fnOut = dstWord;
      ROBU_FN_S_XOR_D: fnOut = srcWord ^ dstWord;
      ROBU_FN_S_OR_D: fnOut = srcWord | dstWord;
      ROBU_FN_NS_AND_ND: fnOut = ~srcWord & ~dstWord;
      ROBU_FN_S_XNOR_D: fnOut = ~(srcWord ^ dstWord);
      ROBU_FN_ND: fnOut = ~dstWord;
      ROBU_FN_S_OR_ND: fnOut = srcWord | ~dstWord;
      ROBU_FN_NS: fnOut = ~srcWord;
      ROBU_FN_NS_OR_D: fnOut = ~srcWord | dstWord;
      ROBU_FN_NS_OR_ND: fnOut = ~srcWord | ~dstWord;
      default: fnOut = 16'hffff;
    endcase
  end

  // Disabled positions keep the destination bit
  assign resWord = (fnOut & maskWord) | (dstWord & ~maskWord); // [RL9] [RL21]

endmodule : robu_logic_fn

`default_nettype wire

// [rtl/robu_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "robu_defs.svh"

// Operation
// RL1 - Six byte registers, all read and write
// RL2 - Software programs registers before blit
// RL3 - Register accesses are byte wide only
// RL4 - Shift by amount in bits 3..0
// RL5 - Bit 4 swaps shifter input halves
// RL6 - Right mask ones at 0 through k
// RL7 - Left mask ones at k through 15
// RL8 - Mask bit 0 is leftmost pixel
// RL9 - Mask one enables operation, zero disables
// RL10 - Function code selects sixteen logic results
// RL11 - Each unit holds its own function
// RL12 - Control bit layout, bits 3,0 reserved
// RL13 - Reset clears control register bits
// RL14 - Preread one or two source words
// RL15 - End left mask when enabled
// RL16 - End right mask only when enabled
// RL17 - Begin left mask when enabled
// RL18 - Begin right mask when enabled
// RL19 - Software loads count as 256 minus N
// RL20 - Blit active bit and low activity
// RL21 - Masked positions keep destination bit
// RL22 - Begin first word, end last, AND
module robu_top
  import robu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [31:0] regAddr,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic regRdValid,
  input wire logic blitStart,
  input wire logic blitStop,
  input wire logic lineStart,
  input wire logic srcValid,
  input wire robu_word_type srcData,
  input wire logic dstValid,
  input wire robu_word_type dstData,
  output robu_word_type resData,
  output logic resValid,
  output logic lineBusy,
  output logic lineDone,
  output logic blitActive,
  output logic blitActiveN
);

  function automatic logic [2:0] regIndex(input logic [31:0] addr);
    if (addr == `ROBU_ADDR_SHIFT)
      regIndex = `ROBU_IDX_SHIFT;
    else if (addr == `ROBU_ADDR_RMASK)
      regIndex = `ROBU_IDX_RMASK;
    else if (addr == `ROBU_ADDR_LMASK)
      regIndex = `ROBU_IDX_LMASK;
    else if (addr == `ROBU_ADDR_FUNC)
      regIndex = `ROBU_IDX_FUNC;
    else if (addr == `ROBU_ADDR_CTRL)
      regIndex = `ROBU_IDX_CTRL;
    else if (addr == `ROBU_ADDR_COUNT)
      regIndex = `ROBU_IDX_COUNT;
    else
      regIndex = `ROBU_IDX_NONE;
  endfunction : regIndex

  function automatic logic [7:0] implMask(input logic [2:0] idx);
    case (idx)
      `ROBU_IDX_SHIFT: implMask = `ROBU_IMPL_SHIFT;
      `ROBU_IDX_RMASK: implMask = `ROBU_IMPL_RMASK;
      `ROBU_IDX_LMASK: implMask = `ROBU_IMPL_LMASK;
      `ROBU_IDX_FUNC: implMask = `ROBU_IMPL_FUNC;
      `ROBU_IDX_CTRL: implMask = `ROBU_IMPL_CTRL;
      `ROBU_IDX_COUNT: implMask = `ROBU_IMPL_COUNT;
      default: implMask = 8'h00;
    endcase
  endfunction : implMask

  logic [7:0] cfg_q [`ROBU_NUM_REGS];
  logic [7:0] regRdData_q, wordCnt_q;
  logic regRdValid_q, firstWord_q, prereadLeft_q, resValid_q;
  logic lineDone_q, blitActive_q, blitActiveN_q, lineBusy_q;
  robu_state_type state_q, state_d;
  logic [31:0] shiftReg_q, shiftReg_d;
  robu_word_type resData_q;
  logic [2:0] wrIdx, rdIdx;
  logic [7:0] ctrl;
  logic unitEn, srcTake, wordTake, lastWord, lineGo;
  robu_word_type rightMask, leftMask, maskSel, shiftedSrc, resWord;
  assign wrIdx = regIndex(regAddr);
  assign rdIdx = regIndex(regAddr);
  assign ctrl = cfg_q[`ROBU_IDX_CTRL];
  assign unitEn = ctrl[`ROBU_CTL_EN]; // [RL12]

  // Configuration store; unimplemented bits are never stored
  genvar r;
  generate
    for (r = 0; r < `ROBU_NUM_REGS; r = r + 1)
    begin : gen_cfg
      always_ff @(posedge sys_clk or negedge nrst)
      begin
        if (!nrst)
          cfg_q[r] <= `ROBU_RST_REG; // [RL13]
        else if (regWrEn && wrIdx == 3'(r))
          cfg_q[r] <= regWrData & implMask(3'(r)); // [RL1] [RL11]
      end
    end
  endgenerate

  // Read path: count register shows the live word counter
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      regRdData_q <= `ROBU_RST_UNMAPPED;
      regRdValid_q <= 1'b0;
    end
    else
    begin
      regRdValid_q <= regRdEn;
      if (regRdEn)
      begin
        if (rdIdx == `ROBU_IDX_NONE)
          regRdData_q <= `ROBU_RST_UNMAPPED;
        else if (rdIdx == `ROBU_IDX_COUNT)
          regRdData_q <= wordCnt_q;
        else
          regRdData_q <= cfg_q[rdIdx]; // [RL1] [RL12]
      end
    end
  end

  robu_mask_gen u_mask_gen (
    .rightIdx(cfg_q[`ROBU_IDX_RMASK][`ROBU_IDX_MSB:`ROBU_IDX_LSB]),
    .leftIdx(cfg_q[`ROBU_IDX_LMASK][`ROBU_IDX_MSB:`ROBU_IDX_LSB]),
    .rightMask(rightMask),
    .leftMask(leftMask)
  );

  assign lineGo = (state_q == ROBU_IDLE) && lineStart && unitEn;
  assign srcTake = (state_q == ROBU_PREREAD) && srcValid;
  assign wordTake = (state_q == ROBU_RUN) && srcValid && dstValid;
  assign lastWord = (wordCnt_q == `ROBU_LAST_COUNT);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ROBU_IDLE:
        if (lineGo)
          state_d = ROBU_PREREAD;
      ROBU_PREREAD:
        if (!unitEn)
          state_d = ROBU_IDLE;
        else if (srcTake && !prereadLeft_q)
          state_d = ROBU_RUN; // [RL14]
      ROBU_RUN:
        if (!unitEn)
          state_d = ROBU_IDLE;
        else if (wordTake && lastWord)
          state_d = ROBU_IDLE;
      default:
        state_d = ROBU_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= ROBU_IDLE;
      lineBusy_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      lineBusy_q <= (state_d != ROBU_IDLE);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      prereadLeft_q <= 1'b0;
    else if (lineGo)
      prereadLeft_q <= ctrl[`ROBU_CTL_PRERD]; // [RL14]
    else if (srcTake)
      prereadLeft_q <= 1'b0;
  end

  // Counter runs from 256-N up to 255 on the last word
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wordCnt_q <= `ROBU_RST_REG;
      firstWord_q <= 1'b0;
    end
    else if (lineGo)
    begin
      wordCnt_q <= cfg_q[`ROBU_IDX_COUNT]; // [RL19]
      firstWord_q <= 1'b1;
    end
    else if (wordTake)
    begin
      wordCnt_q <= wordCnt_q + 8'h01;
      firstWord_q <= 1'b0;
    end
    else if (regWrEn && wrIdx == `ROBU_IDX_COUNT && state_q == ROBU_IDLE)
      wordCnt_q <= regWrData;
  end

  // New word enters the half picked by the swap bit
  always_comb
  begin
    shiftReg_d = shiftReg_q;
    if ((srcTake || wordTake) && cfg_q[`ROBU_IDX_SHIFT][`ROBU_SWAP_BIT])
      shiftReg_d = {shiftReg_q[15:0], srcData}; // [RL5]
    else if (srcTake || wordTake)
      shiftReg_d = {srcData, shiftReg_q[31:16]}; // [RL5]
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      shiftReg_q <= 32'h00000000;
    else
      shiftReg_q <= shiftReg_d;
  end

  // Result uses the word taken this cycle, saving a pipeline stage
  assign shiftedSrc = 16'(shiftReg_d >>
    cfg_q[`ROBU_IDX_SHIFT][`ROBU_SHIFT_MSB:`ROBU_SHIFT_LSB]); // [RL4]

  always_comb
  begin
    maskSel = 16'hffff;
    if (firstWord_q && ctrl[`ROBU_CTL_BEGIN_RIGHT_MASK_EN])
      maskSel = maskSel & rightMask; // [RL18] [RL22]
    if (firstWord_q && ctrl[`ROBU_CTL_BEGIN_LEFT_MASK_EN])
      maskSel = maskSel & leftMask; // [RL17] [RL22]
    if (lastWord && ctrl[`ROBU_CTL_END_RIGHT_MASK_EN])
      maskSel = maskSel & rightMask; // [RL16] [RL22]
    if (lastWord && ctrl[`ROBU_CTL_END_LEFT_MASK_EN])
      maskSel = maskSel & leftMask; // [RL15] [RL22]
  end

  robu_logic_fn u_logic_fn (
    .fnCode(cfg_q[`ROBU_IDX_FUNC][`ROBU_IDX_MSB:`ROBU_IDX_LSB]),
    .srcWord(shiftedSrc),
    .dstWord(dstData),
    .maskWord(maskSel),
    .resWord(resWord)
  );

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      resData_q <= 16'h0000;
      resValid_q <= 1'b0;
      lineDone_q <= 1'b0;
    end
    else
    begin
      resValid_q <= wordTake;
      lineDone_q <= wordTake && lastWord;
      if (wordTake)
        resData_q <= resWord; // [RL10] [RL21]
    end
  end

  // Start wins over a stop in the same cycle
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      blitActive_q <= 1'b0;
      blitActiveN_q <= 1'b1; // [RL20]
    end
    else if (blitStart || blitStop)
    begin
      blitActive_q <= blitStart; // [RL20]
      blitActiveN_q <= !blitStart;
    end
  end

  assign regRdData = regRdData_q;
  assign regRdValid = regRdValid_q;
  assign resData = resData_q;
  assign resValid = resValid_q;
  assign lineBusy = lineBusy_q;
  assign lineDone = lineDone_q;
  assign blitActive = blitActive_q;
  assign blitActiveN = blitActiveN_q;

  // Helper: source words taken before the first destination word
  logic [1:0] prereadSeen_q;
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      prereadSeen_q <= 2'h0;
    else if (lineGo)
      prereadSeen_q <= 2'h0;
    else if (srcTake)
      prereadSeen_q <= prereadSeen_q + 2'h1;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  chk_rd_latency: assert property ( // [RL1]
    regRdEn |=> regRdValid ##1 (!regRdValid || $past(regRdEn)))
    else $error("read answer not one cycle after request");
  chk_fn_readback: assert property ( // [RL1] [RL11]
    (regWrEn && regAddr == `ROBU_ADDR_FUNC && !regRdEn) ##1 !regWrEn ##1
    (regRdEn && !regWrEn && regAddr == `ROBU_ADDR_FUNC)
    |=> regRdData == ($past(regWrData, 3) & `ROBU_IMPL_FUNC))
    else $error("function register read back wrong");
  chk_ctrl_reserved: assert property ( // [RL12]
    (regRdEn && regAddr == `ROBU_ADDR_CTRL)
    |=> regRdData[3] == 1'b0 && regRdData[0] == 1'b0)
    else $error("reserved control bits read nonzero");
  chk_rmask_shape: assert property ( // [RL6]
    rightMask == (16'hffff >>
      (4'hf - cfg_q[`ROBU_IDX_RMASK][`ROBU_IDX_MSB:`ROBU_IDX_LSB])))
    else $error("right mask pattern wrong");
  chk_lmask_shape: assert property ( // [RL7]
    leftMask == (16'hffff <<
      cfg_q[`ROBU_IDX_LMASK][`ROBU_IDX_MSB:`ROBU_IDX_LSB]))
    else $error("left mask pattern wrong");
  chk_preread_count: assert property ( // [RL14]
    (state_q == ROBU_PREREAD && state_d == ROBU_RUN)
    |=> prereadSeen_q == (ctrl[`ROBU_CTL_PRERD] ? 2'h2 : 2'h1))
    else $error("wrong number of source words preread");
  chk_masked_keep: assert property ( // [RL21]
    wordTake |=> ((resData ^ $past(dstData)) & ~$past(maskSel)) == 16'h0)
    else $error("masked position changed destination bit");
  chk_end_rmask_off: assert property ( // [RL16] [RL22]
    (wordTake && lastWord && !firstWord_q && !ctrl[`ROBU_CTL_END_RIGHT_MASK_EN]
      && !ctrl[`ROBU_CTL_END_LEFT_MASK_EN]) |-> maskSel == 16'hffff)
    else $error("end mask applied while disabled");
  chk_line_end: assert property ( // [RL22]
    (wordTake && lastWord) |=> lineDone && resValid && !lineBusy)
    else $error("line did not end on last word");
  chk_blit_flag: assert property ( // [RL20]
    blitStart |=> (blitActive && !blitActiveN))
    else $error("blit activity not shown");
  chk_blit_clear: assert property ( // [RL20]
    (blitStop && !blitStart) |=> (!blitActive && blitActiveN))
    else $error("blit activity not cleared");
  cov_two_preread: cover property (
    lineGo && ctrl[`ROBU_CTL_PRERD] ##[1:20] (state_q == ROBU_RUN));
  cov_single_word: cover property (wordTake && firstWord_q && lastWord);
  cov_multi_line: cover property (lineDone ##[1:50] lineDone);
  cov_blit_run: cover property (blitStart ##[1:100] blitStop);

endmodule : robu_top

`default_nettype wire

// [verification/robu_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none

module robu_cpu_model
  import robu_pkg::*;
(
  input wire logic sys_clk,
  output logic srcValid,
  output robu_word_type srcData,
  output logic dstValid,
  output robu_word_type dstData
);
  robu_word_type srcMem [0:7];
  robu_word_type dstMem [0:7];

  initial
  begin
    srcValid = 1'b0;
    dstValid = 1'b0;
    srcData = 16'h0000;
    dstData = 16'h0000;
  end

  // No ready from the unit: each word stands one cycle, as the unit takes
  // one per valid cycle; idle lines show the inverse, except dstData in slow gaps, so stale data fails
  task automatic run_line(input int nPre, input int nRun, input bit slow);
    int i;
    for (i = 0; i < nPre + nRun; i++)
    begin
      if (slow)
      begin
        @(posedge sys_clk);
        srcValid <= 1'b0;
        dstValid <= 1'b0;
        srcData <= ~srcData;
      end
      @(posedge sys_clk);
      srcValid <= 1'b1;
      srcData <= srcMem[i];
      dstValid <= (i >= nPre);
      dstData <= (i >= nPre) ? dstMem[i - nPre] : ~dstData;
    end
    @(posedge sys_clk);
    srcValid <= 1'b0;
    dstValid <= 1'b0;
    srcData <= ~srcData;
    dstData <= ~dstData;
  endtask : run_line
endmodule : robu_cpu_model

`default_nettype wire

// [verification/tb_raster_op_blit_unit.sv]
`timescale 1ns/1ps
`default_nettype none
`include "robu_defs.svh"

module tb_raster_op_blit_unit
  import robu_pkg::*;
;
  logic sys_clk, nrst, regWrEn, regRdEn, regRdValid;
  logic [31:0] regAddr;
  logic [7:0] regWrData, regRdData;
  logic blitStart, blitStop, lineStart, srcValid, dstValid;
  robu_word_type srcData, dstData, resData;
  logic resValid, lineBusy, lineDone, blitActive, blitActiveN;
  int n_errors, check_count, i;
  logic [31:0] addrs [0:5];
  logic [7:0] impl [0:5];

  robu_top uut (.sys_clk(sys_clk), .nrst(nrst), .regAddr(regAddr),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData),
    .regRdData(regRdData), .regRdValid(regRdValid), .blitStart(blitStart),
    .blitStop(blitStop), .lineStart(lineStart), .srcValid(srcValid),
    .srcData(srcData), .dstValid(dstValid), .dstData(dstData),
    .resData(resData), .resValid(resValid), .lineBusy(lineBusy),
    .lineDone(lineDone), .blitActive(blitActive),
    .blitActiveN(blitActiveN));

  robu_cpu_model part (.sys_clk(sys_clk), .srcValid(srcValid),
    .srcData(srcData), .dstValid(dstValid), .dstData(dstData));

  function automatic robu_word_type fn_ref(logic [3:0] f, robu_word_type s,
    robu_word_type d);
    return ({16{f[0]}} & s & d) | ({16{f[1]}} & s & ~d) |
      ({16{f[2]}} & ~s & d) | ({16{f[3]}} & ~s & ~d);
  endfunction : fn_ref

  task automatic check(input logic [15:0] got, input logic [15:0] exp,
    input string what);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  task automatic reg_wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [31:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    #1;
    check({15'h0, regRdValid}, 16'h0001, "read valid");
    check({8'h0, regRdData}, {8'h0, e}, "read data");
  endtask : reg_rd

  // Expected words come from a shift-register model kept here
  task automatic do_line(input logic [7:0] ctl, input logic [7:0] bsc,
    input logic [3:0] rm, input logic [3:0] lm, input logic [3:0] f,
    input int n, input bit slow);
    int pre, j, k;
    logic [31:0] sh;
    robu_word_type s, m, rmk, lmk;
    robu_word_type exp [0:7];
    pre = ctl[1] ? 2 : 1;
    sh = 32'h0;
    rmk = 16'hffff >> (4'hf - rm);
    lmk = 16'hffff << lm;
    for (j = 0; j < pre + n; j++)
    begin
      sh = bsc[4] ? {sh[15:0], part.srcMem[j]} : {part.srcMem[j], sh[31:16]};
      k = j - pre;
      s = 16'(sh >> bsc[3:0]);
      m = 16'hffff;
      if (k == 0)
        m = m & (ctl[7] ? rmk : 16'hffff) & (ctl[6] ? lmk : 16'hffff);
      if (k == n - 1)
        m = m & (ctl[5] ? rmk : 16'hffff) & (ctl[4] ? lmk : 16'hffff);
      if (k >= 0)
        exp[k] = (fn_ref(f, s, part.dstMem[k]) & m) | (part.dstMem[k] & ~m);
    end
    reg_wr(`ROBU_ADDR_SHIFT, bsc);
    reg_wr(`ROBU_ADDR_RMASK, {4'h0, rm});
    reg_wr(`ROBU_ADDR_LMASK, {4'h0, lm});
    reg_wr(`ROBU_ADDR_FUNC, {4'h0, f});
    reg_wr(`ROBU_ADDR_COUNT, 8'(256 - n));
    reg_wr(`ROBU_ADDR_CTRL, ctl);
    @(posedge sys_clk);
    lineStart <= 1'b1;
    fork
      part.run_line(pre, n, slow);
      begin
        @(posedge sys_clk);
        lineStart <= 1'b0;
        for (k = 0; k < n; k++)
        begin
          j = 0;
          do
          begin
            @(posedge sys_clk);
            #1;
            j++;
          end while (resValid !== 1'b1 && j < 40);
          check({15'h0, resValid}, 16'h0001, "result valid");
          check(resData, exp[k], "result");
          check({15'h0, lineDone}, {15'h0, k == n - 1}, "done");
        end
      end
    join
    check({15'h0, lineBusy}, 16'h0000, "busy after line");
  endtask : do_line

  initial
  begin
    sys_clk = 1'b0;
    forever
      #2.5 sys_clk = ~sys_clk;
  end

  initial
  begin
    #100000;
    n_errors++;
    give_verdict();
  end

  initial
  begin
    {nrst, regWrEn, regRdEn, blitStart, blitStop, lineStart} = 6'h00;
    regAddr = 32'h0;
    regWrData = 8'h00;
    n_errors = 0;
    check_count = 0;
    addrs = '{`ROBU_ADDR_SHIFT, `ROBU_ADDR_RMASK, `ROBU_ADDR_LMASK,
      `ROBU_ADDR_FUNC, `ROBU_ADDR_CTRL, `ROBU_ADDR_COUNT};
    impl = '{8'h1f, 8'h0f, 8'h0f, 8'h0f, 8'hf6, 8'hff};
    for (i = 0; i < 8; i++)
    begin
      part.srcMem[i] = 16'(16'hc35a + 16'h2b71 * i);
      part.dstMem[i] = 16'(16'h9e0f - 16'h1357 * i);
    end
    repeat (5) @(posedge sys_clk);
    #1;
    check({14'h0, blitActive, blitActiveN}, 16'h0001, "reset flag");
    nrst <= 1'b1;
    for (i = 0; i < 6; i++)
      reg_rd(addrs[i], 8'h00);
    for (i = 0; i < 6; i++)
    begin
      reg_wr(addrs[i], 8'hff);
      reg_rd(addrs[i], impl[i]);
    end
    reg_wr(32'h0fffe00c, 8'h00);
    reg_rd(`ROBU_ADDR_FUNC, 8'h0f);
    reg_rd(32'h0fffe00c, 8'h00);
    @(posedge sys_clk);
    blitStart <= 1'b1;
    @(posedge sys_clk);
    blitStart <= 1'b0;
    #1;
    check({14'h0, blitActive, blitActiveN}, 16'h0002, "blit on");
    @(posedge sys_clk);
    blitStop <= 1'b1;
    @(posedge sys_clk);
    blitStop <= 1'b0;
    #1;
    check({14'h0, blitActive, blitActiveN}, 16'h0001, "blit off");
    reg_wr(`ROBU_ADDR_CTRL, 8'hf2);
    @(posedge sys_clk);
    lineStart <= 1'b1;
    @(posedge sys_clk);
    lineStart <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    check({15'h0, lineBusy}, 16'h0000, "disabled start");
    for (i = 0; i < 16; i++)
      do_line(8'h04, 8'h00, 4'h0, 4'h0, 4'(i), 2, 1'b0);
    do_line(8'hf6, 8'h05, 4'h3, 4'hc, 4'h6, 1, 1'b0);
    do_line(8'hd4, 8'h19, 4'hf, 4'h0, 4'h3, 3, 1'b1);
    do_line(8'h26, 8'h0f, 4'h0, 4'hf, 4'hc, 4, 1'b0);
    do_line(8'h54, 8'h13, 4'h7, 4'h5, 4'h9, 2, 1'b1);
    do_line(8'ha4, 8'h00, 4'ha, 4'h3, 4'hd, 5, 1'b0);
    reg_wr(`ROBU_ADDR_CTRL, 8'hf6);
    blitStart <= 1'b1;
    @(posedge sys_clk);
    blitStart <= 1'b0;
    nrst <= 1'b0;
    @(posedge sys_clk);
    nrst <= 1'b1;
    #1;
    check({14'h0, blitActive, blitActiveN}, 16'h0001, "mid reset");
    reg_rd(`ROBU_ADDR_CTRL, 8'h00);
    give_verdict();
  end
endmodule : tb_raster_op_blit_unit

`default_nettype wire
